// [hdl/power_mode_and_write_arbiter.sv]
// core supply switch, harvest output settings and eeprom write arbiter
// assumes pins are asynchronous, request strobes come from clk logic,
// and registers are reached over a zero-wait apb slave
`timescale 1ns/1ps
// Notes on behaviour
// - mode 0, no field, select high: core off
// - mode 0, field up: core on internal supply
// - mode 0, no field, select low: external supply
// - external switch held 0.7 ms after select
// - switch held during serial eeprom writes
// - external mode 0 allows only memory operations
// - field lost, select low: move to external
// - mode 1 harvests only with tunnel/extended
// - mode 1 without links forces resistance zero
// - modes 2,3 stay on with external supply
// - two arbitration modes from config byte
// - mode 0 idle: first writer granted
// - mode 0 rf write during serial: nak
// - mode 0 serial write during rf: error
// - mode 1 field on aborts serial write
// - mode 1 rf access aborts serial write
// - harvesting allowed only in modes 0,1
// - resistance code decode: off,100,50,25 ohm
// - voltage code decode, high codes 1.8 V
module power_mode_and_write_arbiter #(
  parameter int unsigned HOLD_CYC = pm_pkg::SS_HOLD_CYC,
  parameter int unsigned INIT_WAIT_CYC = pm_pkg::INIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins and detectors
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic field_power_on_detect,
  input wire logic external_interface_supply,
  // nonvolatile configuration
  input wire logic nv_load,
  input wire logic [7:0] chip_config_byte_a,
  input wire logic [7:0] chip_config_byte_b,
  // eeprom access requests
  input wire logic rf_wr_req,
  input wire logic rf_rd_req,
  input wire logic ser_wr_req,
  input wire logic ee_wr_done,
  // arbitration answers, one-cycle pulses
  output logic rf_wr_grant,
  output logic rf_nak,
  output logic ser_wr_grant,
  output logic ser_wr_refused,
  output logic ser_wr_abort,
  output logic err_acc,
  // supply switches and serial limits
  output logic core_on_rf_internal_supply,
  output logic core_on_external_supply,
  output logic ser_mem_ops_only,
  output logic init_busy,
  // harvest output control
  output logic harvest_supply_output_oe,
  output logic [2:0] harvest_leg_en,
  output logic [12:0] harvest_mv
);
  // ==========================================================
  // pin synchronisation
  logic [pm_pkg::PIN_W-1:0] raw_pins; // lanes by package index
  pins_if #(.W(pm_pkg::PIN_W)) pin_bus ();

  assign raw_pins[pm_pkg::PIN_SS] = ss_n;
  assign raw_pins[pm_pkg::PIN_SCLK] = sclk;
  assign raw_pins[pm_pkg::PIN_FLD] = field_power_on_detect;
  assign raw_pins[pm_pkg::PIN_EXT] = external_interface_supply;

  // select idles high so its lane resets high
  pin_sampler #(
    .W(pm_pkg::PIN_W),
    .RST_VAL(pm_pkg::PIN_RST)
  ) u_sampler (
    .clk(clk),
    .reset(reset),
    .raw(raw_pins),
    .pins(pin_bus.src)
  );

  wire ss_low = ~pin_bus.lvl[pm_pkg::PIN_SS]; // host selects us
  wire field_on = pin_bus.lvl[pm_pkg::PIN_FLD]; // rectified supply ok
  wire field_rise = pin_bus.rise[pm_pkg::PIN_FLD]; // field just came
  wire sclk_rise = pin_bus.rise[pm_pkg::PIN_SCLK]; // serial clock edge
  wire ext_ok = pin_bus.lvl[pm_pkg::PIN_EXT]; // external supply present

  // ==========================================================
  // configuration
  logic [7:0] cfg_a_q; // power and arbitration mode
  logic [7:0] cfg_b_q; // harvest resistance and voltage
  logic cfg_loaded_q; // nonvolatile bytes applied

  wire apb_wr = psel & penable & pwrite;
  wire hit_a = paddr == pm_pkg::OFS_CFG_A;
  wire hit_b = paddr == pm_pkg::OFS_CFG_B;
  wire hit_st = paddr == pm_pkg::OFS_STATUS;
  wire hit_ev = paddr == pm_pkg::OFS_EVENTS;
  wire hit_hv = paddr == pm_pkg::OFS_HARVEST;
  wire hit_any = hit_a | hit_b | hit_st | hit_ev | hit_hv;

  // nonvolatile load
  // the load wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_a_q <= pm_pkg::CFG_A_RST;
      cfg_b_q <= pm_pkg::CFG_B_RST;
      cfg_loaded_q <= 1'b0;
    end else if (nv_load) begin
      cfg_a_q <= chip_config_byte_a;
      cfg_b_q <= chip_config_byte_b;
      cfg_loaded_q <= 1'b1;
    end else if (apb_wr) begin
      // software may override after load
      if (hit_a) cfg_a_q <= pwdata[7:0];
      if (hit_b) cfg_b_q <= pwdata[7:0];
    end
  end

  wire [1:0] pmode = cfg_a_q[pm_pkg::PMODE_LSB +: 2];
  wire mode0 = pmode == pm_pkg::PM0;
  wire mode1 = pmode == pm_pkg::PM1;
  wire mode_ext = pmode[1]; // modes 2 and 3
  wire arb1 = cfg_a_q[pm_pkg::ARB_BIT];
  wire link_en = cfg_a_q[pm_pkg::TUN_BIT] | cfg_a_q[pm_pkg::EXTM_BIT];

  // ==========================================================
  // write owner state
  pm_pkg::owner_e owner_q; // who is writing eeprom
  pm_pkg::owner_e owner_d;
  wire ser_busy = owner_q == pm_pkg::OWN_SER;

  // ==========================================================
  // external switch hold
  logic [pm_pkg::CNT_W-1:0] hold_q; // cycles left after select rose

  // hold after select
  // reloads while selected, so close transactions keep it closed
  always_ff @(posedge clk) begin
    if (reset) hold_q <= '0;
    else if (ss_low) hold_q <= pm_pkg::CNT_W'(HOLD_CYC);
    else if (hold_q != '0) hold_q <= hold_q - 1'b1;
  end

  wire ext_want = ss_low | (hold_q != '0) | ser_busy;

  // ==========================================================
  // supply selection
  // field connects internal supply
  wire rf_sel_d = (mode0 | mode1) & field_on;
  // mode 0 external path; modes 2,3 follow supply
  // with field lost and select low the external path takes over
  wire ext_sel_d = mode0 ? (~field_on & ext_want) : (mode_ext & ext_ok);

  logic core_rf_q; // core on internal rf supply
  logic core_ext_q; // core on external supply

  // registered so both switches never glitch together
  always_ff @(posedge clk) begin
    if (reset) begin
      core_rf_q <= 1'b0;
      core_ext_q <= 1'b0;
    end else begin
      core_rf_q <= rf_sel_d;
      core_ext_q <= ext_sel_d;
    end
  end

  // ==========================================================
  // initialisation wait on switch activation
  logic [pm_pkg::CNT_W-1:0] init_q; // cycles left of init window
  wire ext_start = ext_sel_d & ~core_ext_q;

  // init window timing
  // a serial clock edge inside the window is flagged, not blocked
  always_ff @(posedge clk) begin
    if (reset) init_q <= '0;
    else if (ext_start) init_q <= pm_pkg::CNT_W'(INIT_WAIT_CYC);
    else if (init_q != '0) init_q <= init_q - 1'b1;
  end

  wire init_on = init_q != '0;
  wire early_clk = sclk_rise & init_on;
  // serial writes wait for config and for the init window
  wire ser_ready = cfg_loaded_q & ~init_on;

  // ==========================================================
  // arbitration
  logic rf_grant_d; // answer pulses, next values
  logic rf_nak_d;
  logic ser_grant_d;
  logic ser_ref_d;
  logic ser_abort_d;
  logic err_d;

  wire abort_ser = ser_busy & arb1 & (field_rise | rf_wr_req | rf_rd_req);

  // owner changes and answer pulses
  always_comb begin
    owner_d = owner_q;
    rf_grant_d = 1'b0;
    rf_nak_d = 1'b0;
    ser_grant_d = 1'b0;
    ser_ref_d = 1'b0;
    ser_abort_d = 1'b0;
    err_d = 1'b0;
    unique case (owner_q)
      pm_pkg::OWN_IDLE: begin
        if (rf_wr_req & cfg_loaded_q) begin
          rf_grant_d = 1'b1;
          owner_d = pm_pkg::OWN_RF;
          // a tie leaves the serial side second
          ser_ref_d = ser_wr_req;
          err_d = ser_wr_req;
        end else if (rf_wr_req) begin
          rf_nak_d = 1'b1;
          ser_ref_d = ser_wr_req;
        end else if (ser_wr_req & ser_ready) begin
          ser_grant_d = 1'b1;
          owner_d = pm_pkg::OWN_SER;
        end else if (ser_wr_req) begin
          ser_ref_d = 1'b1;
        end
      end
      pm_pkg::OWN_RF: begin
        if (ee_wr_done) owner_d = pm_pkg::OWN_IDLE;
        // second rf write while one runs
        rf_nak_d = rf_wr_req;
        if (ser_wr_req) begin
          ser_ref_d = 1'b1;
          err_d = 1'b1;
        end
      end
      pm_pkg::OWN_SER: begin
        ser_ref_d = ser_wr_req;
        if (abort_ser) begin
          // rf side is served at once
          ser_abort_d = 1'b1;
          err_d = 1'b1;
          rf_grant_d = rf_wr_req;
          owner_d = rf_wr_req ? pm_pkg::OWN_RF : pm_pkg::OWN_IDLE;
        end else begin
          rf_nak_d = rf_wr_req;
          if (ee_wr_done) owner_d = pm_pkg::OWN_IDLE;
        end
      end
      default: owner_d = pm_pkg::OWN_IDLE; // illegal code recovers
    endcase
  end

  logic rf_grant_q; // registered answer pulses
  logic rf_nak_q;
  logic ser_grant_q;
  logic ser_ref_q;
  logic ser_abort_q;
  logic err_q;

  // owner and pulse registers
  always_ff @(posedge clk) begin
    if (reset) begin
      owner_q <= pm_pkg::OWN_IDLE;
      {rf_grant_q, rf_nak_q, ser_grant_q} <= 3'h0;
      {ser_ref_q, ser_abort_q, err_q} <= 3'h0;
    end else begin
      owner_q <= owner_d;
      {rf_grant_q, rf_nak_q, ser_grant_q} <= {rf_grant_d, rf_nak_d, ser_grant_d};
      {ser_ref_q, ser_abort_q, err_q} <= {ser_ref_d, ser_abort_d, err_d};
    end
  end

  // ==========================================================
  // serial command limit
  logic mem_only_q; // only memory reads and writes allowed

  always_ff @(posedge clk) begin
    if (reset) mem_only_q <= 1'b0;
    else mem_only_q <= mode0 & ext_sel_d;
  end

  // ==========================================================
  // harvest output
  // harvest allowed
  wire harvest_ok = mode0 | (mode1 & link_en);
  wire [1:0] rreg_eff = harvest_ok ? cfg_b_q[pm_pkg::RREG_LSB +: 2] : 2'h0;
  wire [4:0] vreg = cfg_b_q[pm_pkg::VREG_LSB +: 5];
  wire [12:0] mv_d = (vreg <= pm_pkg::VREG_MAX) ?
    pm_pkg::MV_BASE + 13'(vreg) * pm_pkg::MV_STEP : pm_pkg::MV_LOW;
  logic [2:0] leg_d; // 100, 50, 25 ohm legs

  // resistance decode
  // one leg per nonzero code, zero leaves the pin tristate
  for (genvar i = 0; i < 3; i++) begin : g_leg
    assign leg_d[i] = rreg_eff == 2'(i + 1);
  end

  logic hv_oe_q; // pin driven
  logic [2:0] leg_q;
  logic [12:0] mv_q;

  // harvest registers
  always_ff @(posedge clk) begin
    if (reset) begin
      hv_oe_q <= 1'b0;
      leg_q <= 3'h0;
      mv_q <= pm_pkg::MV_LOW;
    end else begin
      hv_oe_q <= rreg_eff != 2'h0;
      leg_q <= leg_d;
      mv_q <= mv_d;
    end
  end

  // ==========================================================
  // sticky events, write one to clear
  logic [2:0] ev_q;
  wire [2:0] ev_set = {ser_abort_d, early_clk, err_d};
  wire [2:0] ev_clr = (apb_wr & hit_ev) ? pwdata[2:0] : 3'h0;

  // a new event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (reset) ev_q <= 3'h0;
    else ev_q <= (ev_q & ~ev_clr) | ev_set;
  end

  // ==========================================================
  // apb read path
  logic [31:0] st_word; // status view
  logic [31:0] hv_word; // effective harvest view
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;

  // assemble status and harvest words
  always_comb begin
    st_word = 32'h0;
    st_word[pm_pkg::ST_LOADED] = cfg_loaded_q;
    st_word[pm_pkg::ST_CORE_RF] = core_rf_q;
    st_word[pm_pkg::ST_CORE_EXT] = core_ext_q;
    st_word[pm_pkg::ST_INIT] = init_on;
    st_word[pm_pkg::ST_MEMONLY] = mem_only_q;
    st_word[pm_pkg::ST_OWNER_LSB +: 3] = owner_q;
    hv_word = 32'h0;
    hv_word[pm_pkg::HV_RREG_LSB +: 2] = rreg_eff;
    hv_word[pm_pkg::HV_OE] = hv_oe_q;
    hv_word[pm_pkg::HV_LEG_LSB +: 3] = leg_q;
    hv_word[pm_pkg::HV_MV_LSB +: 13] = mv_q;
  end

  // unmapped reads return zero
  assign rd_mux = hit_a ? {24'h0, cfg_a_q} :
                  hit_b ? {24'h0, cfg_b_q} :
                  hit_st ? st_word :
                  hit_ev ? {29'h0, ev_q} :
                  hit_hv ? hv_word : 32'h0;

  // captured in the setup cycle so data comes from a flop
  always_ff @(posedge clk) begin
    if (reset) rdata_q <= 32'h0;
    else if (psel & ~penable) rdata_q <= rd_mux;
  end

  // ==========================================================
  // outputs
  assign prdata = rdata_q;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit_any;
  assign rf_wr_grant = rf_grant_q;
  assign rf_nak = rf_nak_q;
  assign ser_wr_grant = ser_grant_q;
  assign ser_wr_refused = ser_ref_q;
  assign ser_wr_abort = ser_abort_q;
  assign err_acc = err_q;
  assign core_on_rf_internal_supply = core_rf_q;
  assign core_on_external_supply = core_ext_q;
  assign ser_mem_ops_only = mem_only_q;
  assign init_busy = init_on;
  assign harvest_supply_output_oe = hv_oe_q;
  assign harvest_leg_en = leg_q;
  assign harvest_mv = mv_q;
endmodule // power_mode_and_write_arbiter

// [pkg/pm_pkg.sv]
// constants for the supply switch and eeprom write arbiter
// assumes a single 250 MHz clock and an apb register port
package pm_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 250;
  // switch hold after select returns high, in ms
  localparam real SS_HOLD_MS = 0.7;
  // host wait from select low to first serial clock, in us
  localparam real INIT_WAIT_US = 300.0;
  // least times round up to whole cycles
  localparam int unsigned SS_HOLD_CYC = int'($ceil(SS_HOLD_MS * 1000.0 * CLK_MHZ));
  localparam int unsigned INIT_CYC = int'($ceil(INIT_WAIT_US * CLK_MHZ));
  localparam int CNT_W = 18;
  // ==========================================================
  // pin sampler lanes
  localparam int PIN_W = 4;
  localparam int PIN_SS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_FLD = 2;
  localparam int PIN_EXT = 3;
  localparam logic [PIN_W-1:0] PIN_RST = 4'h1;
  // ==========================================================
  // apb map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CFG_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENTS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_HARVEST = 8'h10;
  // ==========================================================
  // config byte a fields
  localparam int PMODE_LSB = 0;
  localparam int ARB_BIT = 2;
  localparam int TUN_BIT = 3;
  localparam int EXTM_BIT = 4;
  localparam logic [7:0] CFG_A_RST = 8'h00;
  // config byte b fields
  localparam int RREG_LSB = 0;
  localparam int VREG_LSB = 2;
  localparam logic [7:0] CFG_B_RST = 8'h00;
  // power modes
  localparam logic [1:0] PM0 = 2'h0;
  localparam logic [1:0] PM1 = 2'h1;
  // harvest voltage decode, millivolts
  localparam logic [4:0] VREG_MAX = 5'h1a;
  localparam logic [12:0] MV_BASE = 13'h076c;
  localparam logic [12:0] MV_STEP = 13'h0064;
  localparam logic [12:0] MV_LOW = 13'h0708;
  // ==========================================================
  // status, event and harvest word fields
  localparam int ST_LOADED = 0;
  localparam int ST_CORE_RF = 1;
  localparam int ST_CORE_EXT = 2;
  localparam int ST_INIT = 3;
  localparam int ST_MEMONLY = 4;
  localparam int ST_OWNER_LSB = 8;
  localparam int EV_CONFLICT = 0;
  localparam int EV_EARLY_CLK = 1;
  localparam int EV_ABORT = 2;
  localparam int HV_RREG_LSB = 0;
  localparam int HV_OE = 2;
  localparam int HV_LEG_LSB = 4;
  localparam int HV_MV_LSB = 16;
  // write owner, one-hot
  typedef enum logic [2:0] {
    OWN_IDLE = 3'b001,
    OWN_RF = 3'b010,
    OWN_SER = 3'b100
  } owner_e;
endpackage

// [pkg/pins_if.sv]
// synchronised pin levels and edges between sampler and core
// assumes all lanes share the one system clock
`timescale 1ns/1ps
interface pins_if #(
  parameter int W = 4
) ();
  // levels after two flops, and one-cycle edge pulses
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// [hdl/pin_sampler.sv]
// two-flop synchronisers with edge detect for asynchronous pins
// assumes raw lanes may change at any time relative to clk
`timescale 1ns/1ps
module pin_sampler #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // raw pins
  input wire logic [W-1:0] raw,
  // synchronised view
  pins_if.src pins
);
  // ==========================================================
  // per lane flops
  logic [W-1:0] meta_q; // first stage, read only by sync_q
  logic [W-1:0] sync_q; // safe level
  logic [W-1:0] prev_q; // last level for edges

  for (genvar i = 0; i < W; i++) begin : g_lane
    // reset to idle level so no false edge at release
    always_ff @(posedge clk) begin
      if (reset) begin
        meta_q[i] <= RST_VAL[i];
        sync_q[i] <= RST_VAL[i];
        prev_q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= raw[i];
        sync_q[i] <= meta_q[i];
        prev_q[i] <= sync_q[i];
      end
    end
  end

  // ==========================================================
  // outputs
  assign pins.lvl = sync_q;
  assign pins.rise = sync_q & ~prev_q;
  assign pins.fall = ~sync_q & prev_q;
endmodule // pin_sampler

// [tb/pm_checker.sv]
// port assertions for the supply switch, harvest and write arbiter
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module pm_checker #(
  parameter int unsigned HOLD_CYC = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic ss_n,
  input wire logic field_power_on_detect,
  // arbiter
  input wire logic rf_wr_req,
  input wire logic ser_wr_req,
  input wire logic rf_wr_grant,
  input wire logic rf_nak,
  input wire logic ser_wr_grant,
  input wire logic ser_wr_refused,
  input wire logic ser_wr_abort,
  input wire logic err_acc,
  // supply and harvest
  input wire logic core_on_rf_internal_supply,
  input wire logic core_on_external_supply,
  input wire logic ser_mem_ops_only,
  input wire logic init_busy,
  input wire logic harvest_supply_output_oe,
  input wire logic [2:0] harvest_leg_en,
  input wire logic [12:0] harvest_mv
);
  // ==========================================
  // cycles the raw select has been high, saturating
  logic [31:0] ss_high_q, ss_high_d;
  assign ss_high_d = !ss_n ? 32'h0 : ss_high_q + {31'h0, ~&ss_high_q};
  // cleared by reset so a stale count never excuses an early drop
  always_ff @(posedge clk) begin
    if (reset) begin
      ss_high_q <= 32'h0;
    end else begin
      ss_high_q <= ss_high_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================
  // properties
  property p_rf_ans;
    rf_wr_req |=> rf_wr_grant ^ rf_nak;
  endproperty
  a_rf_ans: assert property (p_rf_ans) else $error("rf write answer");
  property p_ser_ans;
    ser_wr_req |=> ser_wr_grant ^ ser_wr_refused;
  endproperty
  a_ser_ans: assert property (p_ser_ans) else $error("serial write answer");
  property p_abort;
    ser_wr_abort |-> err_acc && !ser_wr_grant;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without error");
  property p_oe;
    harvest_supply_output_oe == (harvest_leg_en != 3'h0) && $onehot0(harvest_leg_en);
  endproperty
  a_oe: assert property (p_oe) else $error("harvest legs");
  property p_mv;
    harvest_mv == 13'h708 || (harvest_mv >= 13'h76c && harvest_mv <= 13'h1194
      && (harvest_mv - 13'h76c) % 13'h64 == 13'h0);
  endproperty
  a_mv: assert property (p_mv) else $error("harvest voltage");
  property p_hold;
    $fell(core_on_external_supply) && $past(ser_mem_ops_only) && !field_power_on_detect
      |-> ss_high_q >= HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("switch opened early");
  property p_init;
    $rose(ser_mem_ops_only) |-> init_busy;
  endproperty
  a_init: assert property (p_init) else $error("no init window");
  property p_memo;
    ser_mem_ops_only |-> core_on_external_supply && !core_on_rf_internal_supply;
  endproperty
  a_memo: assert property (p_memo) else $error("mem only off supply");
endmodule // pm_checker

// [tb/host_model.sv]
// host side model: drives select and serial clock frames
// assumes the bench raises frame_req once per frame
`timescale 1ns/1ps
module host_model #(
  parameter int INIT_NS = 140
) (
  // frame control
  input wire logic frame_req,
  input wire logic early,
  // serial pins
  output logic ss_n,
  output logic sclk
);
  // idle: select high, clock parked low between frames
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
  end
  always @(posedge frame_req) begin
    #1 ss_n = 1'b0;
    // wait before clocking, skipped only on purpose
    if (!early) begin
      #(INIT_NS);
    end
    repeat (8) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 ss_n = 1'b1;
  end
endmodule // host_model

// [tb/power_mode_and_write_arbiter_tb_top.sv]
// bench for the supply switch, harvest settings and write arbiter
// assumes shortened hold and init counts and a zero-wait apb slave
`timescale 1ns/1ps
module power_mode_and_write_arbiter_tb_top;
  // ==========================================
  // stimulus and observed signals
  localparam int HOLD = 40;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, cfg_a = 8'h00, cfg_b = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, perr, ss_n, sclk, fld = 1'b0, xsup = 1'b0, nv_load = 1'b0;
  logic rfw = 1'b0, rfr = 1'b0, serw = 1'b0, done = 1'b0, frame_req = 1'b0, early = 1'b0;
  logic rfg, nak, sg, sref, sab, err, c_rf, c_ext, memo, ibusy, oe, ab_seen = 1'b0;
  logic [2:0] legs;
  logic [12:0] mv;
  int fail_count = 0, compares = 0;
  power_mode_and_write_arbiter #(.HOLD_CYC(HOLD), .INIT_WAIT_CYC(20)) u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ss_n(ss_n), .sclk(sclk), .field_power_on_detect(fld), .external_interface_supply(xsup),
    .nv_load(nv_load), .chip_config_byte_a(cfg_a), .chip_config_byte_b(cfg_b),
    .rf_wr_req(rfw), .rf_rd_req(rfr), .ser_wr_req(serw), .ee_wr_done(done),
    .rf_wr_grant(rfg), .rf_nak(nak), .ser_wr_grant(sg), .ser_wr_refused(sref),
    .ser_wr_abort(sab), .err_acc(err), .core_on_rf_internal_supply(c_rf),
    .core_on_external_supply(c_ext), .ser_mem_ops_only(memo), .init_busy(ibusy),
    .harvest_supply_output_oe(oe), .harvest_leg_en(legs), .harvest_mv(mv));
  host_model u_host (.frame_req(frame_req), .early(early), .ss_n(ss_n), .sclk(sclk));
  // 250 MHz clock; sticky abort seen flag
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (sab) ab_seen <= 1'b1;
  // ==========================================
  // shared tasks
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ck1(input logic g, input logic e);
    ck({31'h0, g}, {31'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // apb: setup, then access until pready; held until that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle request pulse; returns in the answer cycle
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: rfw <= 1'b1;
      1: rfr <= 1'b1;
      2: serw <= 1'b1;
      default: done <= 1'b1;
    endcase
    @(posedge clk);
    {rfw, rfr, serw, done} <= 4'h0;
    #1;
  endtask
  task automatic load(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    nv_load <= 1'b1;
    cfg_a <= a;
    cfg_b <= b;
    @(posedge clk);
    nv_load <= 1'b0;
    cyc(2);
  endtask
  task automatic frame(input logic e);
    @(posedge clk);
    early <= e;
    frame_req <= 1'b1;
    @(posedge clk);
    frame_req <= 1'b0;
    wait (ss_n === 1'b0);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, pm_pkg::OFS_STATUS, 32'h0);
    ck(q & 32'h1, 32'h0);
    apb(1'b0, pm_pkg::OFS_CFG_A, 32'h0);
    ck(q & 32'h1f, 32'h0);
    apb(1'b1, pm_pkg::OFS_CFG_B, 32'h7f);
    apb(1'b0, pm_pkg::OFS_CFG_B, 32'h0);
    ck(q & 32'h7f, 32'h7f);
    apb(1'b1, 8'h14, 32'h0);
    ck1(perr, 1'b1);
    fire(0);
    ck1(nak, 1'b1);
    fire(2);
    ck1(sref, 1'b1);
    ck({19'h0, mv}, 32'h708);
  endtask
  task automatic t_harvest();
    int vs[5] = '{0, 13, 26, 27, 31};
    logic [31:0] e;
    for (int r = 0; r < 4; r++) begin
      load(8'h00, 8'(r));
      ck({29'h0, legs}, (r == 0) ? 32'h0 : 32'h1 << (r - 1));
      ck1(oe, r != 0);
    end
    foreach (vs[i]) begin
      load(8'h00, 8'(vs[i] << 2));
      e = (vs[i] < 27) ? 32'(pm_pkg::MV_BASE) + 32'(vs[i]) * 32'h64 : 32'h708;
      ck({19'h0, mv}, e);
    end
    load(8'h01, 8'h03);
    ck1(oe, 1'b0);
    apb(1'b0, pm_pkg::OFS_HARVEST, 32'h0);
    ck(q & 32'h3, 32'h0);
    load(8'h09, 8'h03);
    ck({29'h0, legs}, 32'h4);
    load(8'h11, 8'h02);
    ck({29'h0, legs}, 32'h2);
    load(8'h02, 8'h03);
    ck1(oe, 1'b0);
    load(8'h03, 8'h01);
    ck1(oe, 1'b0);
  endtask
  task automatic t_supply();
    load(8'h00, 8'h00);
    ck1(c_ext | c_rf, 1'b0);
    frame(1'b1);
    cyc(5);
    ck1(c_ext, 1'b1);
    ck1(memo, 1'b1);
    ck1(ibusy, 1'b1);
    wait (ss_n === 1'b1);
    cyc(HOLD - 5);
    ck1(c_ext, 1'b1);
    cyc(12);
    ck1(c_ext, 1'b0);
    apb(1'b0, pm_pkg::OFS_EVENTS, 32'h0);
    ck(q & 32'h2, 32'h2);
    frame(1'b0);
    cyc(30);
    fire(2);
    ck1(sg, 1'b1);
    wait (ss_n === 1'b1);
    cyc(HOLD + 12);
    ck1(c_ext, 1'b1);
    fire(3);
    cyc(5);
    ck1(c_ext, 1'b0);
    @(posedge clk);
    fld <= 1'b1;
    frame(1'b0);
    cyc(10);
    ck1(c_rf & ~c_ext, 1'b1);
    @(posedge clk);
    fld <= 1'b0;
    cyc(5);
    ck1(c_ext, 1'b1);
    wait (ss_n === 1'b1);
    cyc(HOLD + 12);
  endtask
  task automatic t_arb0();
    load(8'h00, 8'h00);
    fire(2);
    ck1(sg, 1'b1);
    fire(0);
    ck1(nak, 1'b1);
    fire(3);
    fire(0);
    ck1(rfg, 1'b1);
    fire(2);
    ck1(sref & err, 1'b1);
    fire(3);
    apb(1'b0, pm_pkg::OFS_EVENTS, 32'h0);
    ck(q & 32'h1, 32'h1);
    apb(1'b1, pm_pkg::OFS_EVENTS, 32'h7);
    apb(1'b0, pm_pkg::OFS_EVENTS, 32'h0);
    ck(q & 32'h7, 32'h0);
  endtask
  task automatic t_arb1();
    load(8'h04, 8'h00);
    @(posedge clk);
    fld <= 1'b1;
    cyc(5);
    fire(2);
    ck1(sg, 1'b1);
    fire(1);
    ck1(sab & err, 1'b1);
    fire(3);
    fire(2);
    ck1(sg, 1'b1);
    fire(0);
    ck1(sab & rfg, 1'b1);
    fire(3);
    @(posedge clk);
    fld <= 1'b0;
    cyc(5);
    fire(2);
    ab_seen = 1'b0;
    @(posedge clk);
    fld <= 1'b1;
    cyc(6);
    ck1(ab_seen, 1'b1);
    fire(3);
    apb(1'b0, pm_pkg::OFS_EVENTS, 32'h0);
    ck(q & 32'h5, 32'h5);
  endtask
  task automatic t_mode23();
    for (int m = 2; m < 4; m++) begin
      load(8'(m), 8'h00);
      @(posedge clk);
      xsup <= 1'b1;
      cyc(5);
      ck1(c_ext & ~c_rf, 1'b1);
      @(posedge clk);
      fld <= 1'b0;
      cyc(5);
      ck1(c_ext, 1'b1);
      @(posedge clk);
      xsup <= 1'b0;
      cyc(5);
      ck1(c_ext, 1'b0);
    end
  endtask
  // ==========================================
  // verdict, watchdog and main sequence
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_harvest();
    t_supply();
    t_arb0();
    t_arb1();
    t_mode23();
    complete_run();
  end
endmodule // power_mode_and_write_arbiter_tb_top
bind power_mode_and_write_arbiter pm_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (.clk, .reset,
  .ss_n, .field_power_on_detect, .rf_wr_req, .ser_wr_req, .rf_wr_grant, .rf_nak,
  .ser_wr_grant, .ser_wr_refused, .ser_wr_abort, .err_acc, .core_on_rf_internal_supply,
  .core_on_external_supply, .ser_mem_ops_only, .init_busy, .harvest_supply_output_oe,
  .harvest_leg_en, .harvest_mv);
